// file: design/gpio_pkg.sv
// constants for the pin configuration block: map, fields, codes, timing
package gpio_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] PIN_CONFIG_OFF = 8'h88;
    localparam logic [7:0] IRQ_STATUS_OFF = 8'hc0;
    localparam logic [7:0] IRQ_ENABLE_OFF = 8'hc4;

    // ==========================================================
    // field positions of pin_config_reg
    localparam int PIN_VALUE_LSB = 0;
    localparam int EXTRA_OUT_LSB = 3;
    localparam int DIRECTION_LSB = 8;
    localparam int DRIVE_TYPE_LSB = 16;
    localparam int EE_FUNC_LSB = 20;
    localparam int IRQ_LEVEL_LSB = 24;
    localparam int LED_SELECT_LSB = 28;
    localparam int NUM_PINS = 3;

    // writable bits: 30:28, 26:24, 22:20, 18:16, 10:8, 4:3 (2:0 written, read from pins)
    localparam logic [31:0] CFG_WMASK = 32'h7777_071f;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    // ==========================================================
    // eeprom pin function codes
    localparam logic [2:0] EE_FUNC_EEPROM = 3'h0;
    localparam logic [2:0] EE_FUNC_EXTRA = 3'h1;
    localparam logic [2:0] EE_FUNC_RSVD_A = 3'h2;
    localparam logic [2:0] EE_FUNC_XA_RXDV = 3'h3;
    localparam logic [2:0] EE_FUNC_RSVD_B = 3'h4;
    localparam logic [2:0] EE_FUNC_TXEN_XB = 3'h5;
    localparam logic [2:0] EE_FUNC_TXEN_RXDV = 3'h6;
    localparam logic [2:0] EE_FUNC_CLOCKS = 3'h7;

    // ==========================================================
    // timing
    localparam int CLK_MHZ = 25;
    localparam int FILTER_NS = 40;
    localparam int FILTER_CYC_RAW = (FILTER_NS * CLK_MHZ + 999) / 1000;
    localparam int FILTER_CYC = (FILTER_CYC_RAW < 1) ? 1 : FILTER_CYC_RAW;

endpackage

// file: design/irq_if.sv
// carrier between the register core and the pin level detector
`timescale 1ns/1ns
interface irq_if #(
    parameter int N = 3
);
    logic [N-1:0] level;
    logic [N-1:0] polarity;
    logic [N-1:0] hit;

    modport detect (
        input level,
        input polarity,
        output hit
    );
    modport core (
        output level,
        output polarity,
        input hit
    );
endinterface

// file: design/pin_level_detect.sv
// qualifies pin levels as interrupt conditions after a minimum active time
`timescale 1ns/1ns
module pin_level_detect #(
    parameter int N = 3,
    parameter int CW = 4
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    irq_if.detect irq
);

    // ==========================================================
    // per pin run length of the active level
    localparam logic [CW-1:0] LIMIT = CW'(gpio_pkg::FILTER_CYC + 1);

    logic [N-1:0] active;
    logic [CW-1:0] run_r [N];

    always_comb begin
        active = ~(irq.level ^ irq.polarity);
    end

    // must be seen active at more than FILTER_CYC edges, i.e. longer than the filter time
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < N; i++) begin
            if (sys_rst || !active[i]) begin
                run_r[i] <= '0;
            end else if (run_r[i] != LIMIT) begin
                run_r[i] <= run_r[i] + CW'(1);
            end
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            irq.hit[i] = (run_r[i] == LIMIT);
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    filter_min_time_a: assert property ($rose(irq.hit[0]) |-> $past(active[0]) && $past(active[0], 2))
        else $error("pin 0 qualified after too short an active time");

    filter_drop_a: assert property (!active[1] |=> !irq.hit[1])
        else $error("pin 1 qualified while inactive");

endmodule

// file: design/gpio_led_pin_config.sv
// gpio, led and eeprom pin configuration block with wishbone register access
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ns
module gpio_led_pin_config #(
    parameter int N = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // general purpose pins
    input wire logic [N-1:0] gpio_in,
    output logic [N-1:0] gpio_out,
    output logic [N-1:0] gpio_oe_n,
    input wire logic [N-1:0] led_in,
    // eeprom pins
    input wire logic eeprom_data_pin_in,
    output logic eeprom_data_pin_out,
    output logic eeprom_data_pin_oe_n,
    output logic eeprom_clock_pin,
    // eeprom controller side
    input wire logic ee_data_drive,
    input wire logic ee_data_out,
    input wire logic ee_clock,
    output logic ee_data_in,
    // debug signals
    input wire logic mii_tx_en,
    input wire logic mii_rx_dv,
    input wire logic mii_tx_clk,
    input wire logic mii_rx_clk
);

    // ==========================================================
    // declarations
    logic [31:0] cfg_r;
    logic [N-1:0] status_r;
    logic [N-1:0] status_nxt;
    logic [N-1:0] enable_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic irq_r;
    logic req;
    logic wr;
    logic [N-1:0] clr;
    logic [N-1:0] gp_out_nxt;
    logic [N-1:0] gp_oe_n_nxt;
    logic [N-1:0] gp_out_r;
    logic [N-1:0] gp_oe_n_r;
    logic ee_dat_nxt;
    logic ee_dat_oe_n_nxt;
    logic ee_clk_nxt;
    logic ee_dat_r;
    logic ee_dat_oe_n_r;
    logic ee_clk_r;
    logic ee_di_r;
    logic [2:0] ee_func;
    logic [1:0] extra_val;

    irq_if #(.N(N)) irq_bus ();

    // ==========================================================
    // helpers
    function automatic logic [31:0] merge_lanes(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0] sel
    );
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge_lanes = (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic [N-1:0] field(
        input logic [31:0] v,
        input int lsb
    );
        field = N'(v >> lsb);
    endfunction

    // ==========================================================
    // one wait state, ack for one cycle; a write lands at the edge the master sees ack
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_r;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // unmapped addresses still ack, read zero, writes dropped
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            if (wb_adr_i == gpio_pkg::PIN_CONFIG_OFF) begin
                rdata_r <= (cfg_r & gpio_pkg::CFG_WMASK & ~32'h0000_0007) | 32'(gpio_in);
            end else if (wb_adr_i == gpio_pkg::IRQ_STATUS_OFF) begin
                rdata_r <= 32'(status_r);
            end else if (wb_adr_i == gpio_pkg::IRQ_ENABLE_OFF) begin
                rdata_r <= 32'(enable_r);
            end else begin
                rdata_r <= 32'h0000_0000;
            end
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;

    // ==========================================================
    // configuration register
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cfg_r <= gpio_pkg::CFG_RESET;
        end else if (wr && wb_adr_i == gpio_pkg::PIN_CONFIG_OFF) begin
            cfg_r <= merge_lanes(cfg_r, wb_dat_i, wb_sel_i) & gpio_pkg::CFG_WMASK;
        end
    end

    assign ee_func = cfg_r[gpio_pkg::EE_FUNC_LSB +: 3];
    assign extra_val = cfg_r[gpio_pkg::EXTRA_OUT_LSB +: 2];

    // ==========================================================
    // interrupt status, enable and output
    assign irq_bus.level = gpio_in;
    assign irq_bus.polarity = field(cfg_r, gpio_pkg::IRQ_LEVEL_LSB);

    pin_level_detect #(.N(N), .CW(4)) u_detect (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .irq(irq_bus)
    );

    always_comb begin
        clr = '0;
        if (wr && wb_adr_i == gpio_pkg::IRQ_STATUS_OFF && wb_sel_i[0]) begin
            clr = wb_dat_i[N-1:0];
        end
        // a level still present re-sets its bit over the clear
        status_nxt = (status_r & ~clr) | irq_bus.hit;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_r <= gpio_pkg::IRQ_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            enable_r <= gpio_pkg::IRQ_RESET;
        end else if (wr && wb_adr_i == gpio_pkg::IRQ_ENABLE_OFF && wb_sel_i[0]) begin
            enable_r <= wb_dat_i[N-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & enable_r);
        end
    end

    assign irq_o = irq_r;

    // ==========================================================
    // general purpose pin drivers
    always_comb begin
        logic led;
        logic drv;
        logic val;
        led = 1'b0;
        drv = 1'b0;
        val = 1'b0;
        for (int i = 0; i < N; i++) begin
            led = cfg_r[gpio_pkg::LED_SELECT_LSB + i];
            drv = cfg_r[gpio_pkg::DRIVE_TYPE_LSB + i];
            val = led ? led_in[i] : cfg_r[gpio_pkg::PIN_VALUE_LSB + i];
            if (!led && !cfg_r[gpio_pkg::DIRECTION_LSB + i]) begin
                gp_out_nxt[i] = 1'b0;
                gp_oe_n_nxt[i] = 1'b1;
            end else if (drv) begin
                gp_out_nxt[i] = val;
                gp_oe_n_nxt[i] = 1'b0;
            end else begin
                // open drain: pull low for a zero, release for a one
                gp_out_nxt[i] = 1'b0;
                gp_oe_n_nxt[i] = val;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            gp_out_r <= '0;
            gp_oe_n_r <= '1;
        end else begin
            gp_out_r <= gp_out_nxt;
            gp_oe_n_r <= gp_oe_n_nxt;
        end
    end

    assign gpio_out = gp_out_r;
    assign gpio_oe_n = gp_oe_n_r;

    // ==========================================================
    // eeprom pin routing
    // outputs are registered, so routed debug clocks only show at half the
    // clock rate or slower; good enough for observation, not for timing
    always_comb begin
        ee_dat_nxt = 1'b0;
        ee_dat_oe_n_nxt = 1'b1;
        ee_clk_nxt = 1'b0;
        case (ee_func)
            gpio_pkg::EE_FUNC_EEPROM: begin
                ee_dat_nxt = ee_data_out;
                ee_dat_oe_n_nxt = !ee_data_drive;
                ee_clk_nxt = ee_clock;
            end
            gpio_pkg::EE_FUNC_EXTRA: begin
                ee_dat_nxt = extra_val[0];
                ee_dat_oe_n_nxt = 1'b0;
                ee_clk_nxt = extra_val[1];
            end
            gpio_pkg::EE_FUNC_XA_RXDV: begin
                ee_dat_nxt = extra_val[0];
                ee_dat_oe_n_nxt = 1'b0;
                ee_clk_nxt = mii_rx_dv;
            end
            gpio_pkg::EE_FUNC_TXEN_XB: begin
                ee_dat_nxt = mii_tx_en;
                ee_dat_oe_n_nxt = 1'b0;
                ee_clk_nxt = extra_val[1];
            end
            gpio_pkg::EE_FUNC_TXEN_RXDV: begin
                ee_dat_nxt = mii_tx_en;
                ee_dat_oe_n_nxt = 1'b0;
                ee_clk_nxt = mii_rx_dv;
            end
            gpio_pkg::EE_FUNC_CLOCKS: begin
                ee_dat_nxt = mii_tx_clk;
                ee_dat_oe_n_nxt = 1'b0;
                ee_clk_nxt = mii_rx_clk;
            end
            default: begin
                // reserved codes leave both pins quiet
                ee_dat_nxt = 1'b0;
                ee_dat_oe_n_nxt = 1'b1;
                ee_clk_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ee_dat_r <= 1'b0;
            ee_dat_oe_n_r <= 1'b1;
            ee_clk_r <= 1'b0;
            ee_di_r <= 1'b0;
        end else begin
            ee_dat_r <= ee_dat_nxt;
            ee_dat_oe_n_r <= ee_dat_oe_n_nxt;
            ee_clk_r <= ee_clk_nxt;
            ee_di_r <= eeprom_data_pin_in;
        end
    end

    assign eeprom_data_pin_out = ee_dat_r;
    assign eeprom_data_pin_oe_n = ee_dat_oe_n_r;
    assign eeprom_clock_pin = ee_clk_r;
    assign ee_data_in = ee_di_r;

    // ==========================================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    led_drive_a: assert property (!$past(sys_rst) && $past(cfg_r[28]) && $past(cfg_r[16]) |->
        gpio_out[0] == $past(led_in[0]) && !gpio_oe_n[0])
        else $error("led pin 0 not driven from led input");

    open_drain_a: assert property (!$past(cfg_r[17]) |-> gpio_out[1] == 1'b0)
        else $error("open drain pin 1 drove a high level");

    input_release_a: assert property (!$past(cfg_r[10]) && !$past(cfg_r[30]) |-> gpio_oe_n[2])
        else $error("input pin 2 was driven");

    pin_readback_a: assert property (req && !wb_we_i && wb_adr_i == 8'h88 |=>
        wb_ack_o && wb_dat_o[2:0] == $past(gpio_in))
        else $error("read did not return sensed pin levels");

    status_set_a: assert property (irq_bus.hit[0] |=> status_r[0])
        else $error("qualified level did not set status");

    irq_gate_a: assert property (status_r[1] && enable_r[1] |=> irq_o)
        else $error("enabled status did not raise interrupt");

    irq_mask_a: assert property (enable_r == 3'h0 |=> !irq_o)
        else $error("interrupt raised with all enables off");

    extra_route_a: assert property (!$past(sys_rst) && $past(ee_func) == 3'h1 |->
        eeprom_clock_pin == $past(extra_val[1]) && eeprom_data_pin_out == $past(extra_val[0]))
        else $error("extra outputs not routed to eeprom pins");

    eeprom_route_a: assert property (!$past(sys_rst) && $past(ee_func) == 3'h0 |->
        eeprom_data_pin_oe_n == !$past(ee_data_drive) && eeprom_clock_pin == $past(ee_clock))
        else $error("eeprom interface not routed to its pins");

    reset_zero_a: assert property ($past(sys_rst) |-> cfg_r == 32'h0 && status_r == 3'h0)
        else $error("state not zero after reset");

    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    irq_seen_c: cover property (irq_o);
    led_mode_c: cover property (cfg_r[28] && !gpio_oe_n[0]);
    clock_route_c: cover property (ee_func == 3'h7);
    status_clear_c: cover property (status_r[0] ##1 !status_r[0]);

endmodule

// file: tb/pin_board.sv
// board side of the pins: pull-ups, external drivers and the serial eeprom data line
`timescale 1ns/1ns
module pin_board (
    input wire logic [2:0] gpio_out,
    input wire logic [2:0] gpio_oe_n,
    input wire logic [2:0] ext_en,
    input wire logic [2:0] ext_val,
    output logic [2:0] gpio_in,
    input wire logic ee_out,
    input wire logic ee_oe_n,
    input wire logic mem_en,
    input wire logic mem_val,
    output logic ee_in
);
    // ==========================================================
    // wire resolution
    // external drivers only act on a released pin, so no fight is modelled
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            gpio_in[i] = !gpio_oe_n[i] ? gpio_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
    // eeprom answers only while the data pin is released; pull-up otherwise
    assign ee_in = !ee_oe_n ? ee_out : (mem_en ? mem_val : 1'b1);
endmodule

// file: tb/gpio_led_pin_config_bench.sv
// self-checking bench for the gpio, led and eeprom pin configuration block
`timescale 1ns/1ns
module gpio_led_pin_config_bench;
    logic ref_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, seed, cfg, w, rd;
    logic [2:0] gpio_in, gpio_out, gpio_oe_n, led_in, ext_en, ext_val, pin_lvl, act;
    logic eeprom_data_pin_in, eeprom_data_pin_out, eeprom_data_pin_oe_n, eeprom_clock_pin;
    logic ee_data_drive, ee_data_out, ee_clock, ee_data_in, mem_en, mem_val;
    logic mii_tx_en, mii_rx_dv, mii_tx_clk, mii_rx_clk;
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;

    gpio_led_pin_config #(.N(3)) gpio_led_pin_config_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .irq_o(irq_o), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .led_in(led_in), .eeprom_data_pin_in(eeprom_data_pin_in),
        .eeprom_data_pin_out(eeprom_data_pin_out), .eeprom_data_pin_oe_n(eeprom_data_pin_oe_n),
        .eeprom_clock_pin(eeprom_clock_pin), .ee_data_drive(ee_data_drive),
        .ee_data_out(ee_data_out), .ee_clock(ee_clock), .ee_data_in(ee_data_in),
        .mii_tx_en(mii_tx_en), .mii_rx_dv(mii_rx_dv), .mii_tx_clk(mii_tx_clk),
        .mii_rx_clk(mii_rx_clk));
    pin_board pin_board_i (.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .ext_en(ext_en),
        .ext_val(ext_val), .gpio_in(gpio_in), .ee_out(eeprom_data_pin_out),
        .ee_oe_n(eeprom_data_pin_oe_n), .mem_en(mem_en), .mem_val(mem_val),
        .ee_in(eeprom_data_pin_in));

    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h8020_0003) : (s >> 1);
    endfunction

    // {oe_n, out} of a gpio pin; open drain releases for a one
    function automatic logic [1:0] exp_pin(input logic [31:0] c, input int i);
        logic v;
        v = c[28 + i] ? led_in[i] : c[i];
        if (!c[28 + i] && !c[8 + i]) return 2'h2;
        return c[16 + i] ? {1'b0, v} : {v, 1'b0};
    endfunction

    // {oe_n, data out, clock} of the eeprom pins
    function automatic logic [2:0] exp_ee(input logic [31:0] c);
        case (c[22:20])
            3'h0: return {!ee_data_drive, ee_data_out, ee_clock};
            3'h1: return {1'b0, c[3], c[4]};
            3'h3: return {1'b0, c[3], mii_rx_dv};
            3'h5: return {1'b0, mii_tx_en, c[4]};
            3'h6: return {1'b0, mii_tx_en, mii_rx_dv};
            3'h7: return {1'b0, mii_tx_clk, mii_rx_clk};
            default: return 3'h4;
        endcase
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                      output logic [31:0] q);
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic check_pins(input logic [31:0] c);
        logic [1:0] p;
        logic [2:0] e;
        for (int i = 0; i < 3; i++) begin
            p = exp_pin(c, i);
            chk("pin_oe_n", 32'(p[1]), 32'(gpio_oe_n[i]));
            if (!p[1]) chk("pin_out", 32'(p[0]), 32'(gpio_out[i]));
            pin_lvl[i] = !p[1] ? p[0] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
        e = exp_ee(c);
        chk("ee_oe_n", 32'(e[2]), 32'(eeprom_data_pin_oe_n));
        if (!e[2]) chk("ee_out", 32'(e[1]), 32'(eeprom_data_pin_out));
        chk("ee_clk", 32'(e[0]), 32'(eeprom_clock_pin));
        chk("ee_in", 32'(!e[2] ? e[1] : (mem_en ? mem_val : 1'b1)), 32'(ee_data_in));
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 6000) begin
            error_cnt++;
            test_done();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        sys_rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {led_in, ext_en, ext_val, mem_en, mem_val} = '0;
        {ee_data_drive, ee_data_out, ee_clock} = '0;
        {mii_tx_en, mii_rx_dv, mii_tx_clk, mii_rx_clk} = '0;
        seed = 32'hb3ee_b684;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check_pins(32'h0);
        wb(1'b0, gpio_pkg::PIN_CONFIG_OFF, 32'h0, rd);
        chk("cfg_reset", 32'h7, rd);
        wb(1'b0, gpio_pkg::IRQ_ENABLE_OFF, 32'h0, rd);
        chk("enable_reset", 32'h0, rd);
        wb(1'b1, 8'h40, 32'hffff_ffff, rd);
        wb(1'b0, 8'h40, 32'h0, rd);
        chk("unmapped", 32'h0, rd);
        // first pass writes all ones to expose reserved bits
        for (int k = 0; k < 40; k++) begin
            seed = lfsr_next(seed);
            w = (k == 0) ? 32'hffff_ffff : seed;
            if (k != 0) w[22:20] = codes[int'(seed[31:29]) % 6];
            cfg = w & gpio_pkg::CFG_WMASK;
            wb(1'b1, gpio_pkg::PIN_CONFIG_OFF, w, rd);
            seed = lfsr_next(seed);
            // controller traffic moves at the same edge as the selector write lands
            {led_in, ext_en, ext_val} <= seed[8:0];
            {ee_data_drive, ee_data_out, ee_clock, mem_en, mem_val} <= seed[13:9];
            {mii_tx_en, mii_rx_dv, mii_tx_clk, mii_rx_clk} <= seed[17:14];
            repeat (4) @(posedge ref_clk);
            check_pins(cfg);
            wb(1'b0, gpio_pkg::PIN_CONFIG_OFF, 32'h0, rd);
            chk("cfg_read", (cfg & ~32'h7) | 32'(pin_lvl), rd);
        end
        for (int i = 0; i < 3; i++) begin
            for (int pol = 0; pol < 2; pol++) begin
                act = 3'h1 << i;
                ext_en <= 3'h7;
                ext_val <= pol[0] ? 3'h0 : 3'h7;
                wb(1'b1, gpio_pkg::PIN_CONFIG_OFF, pol[0] ? 32'h0700_0000 : 32'h0, rd);
                wb(1'b1, gpio_pkg::IRQ_ENABLE_OFF, 32'(act), rd);
                repeat (4) @(posedge ref_clk);
                wb(1'b1, gpio_pkg::IRQ_STATUS_OFF, 32'h7, rd);
                wb(1'b0, gpio_pkg::IRQ_STATUS_OFF, 32'h0, rd);
                chk("status_idle", 32'h0, rd);
                // a single cycle is not longer than the filter time
                @(posedge ref_clk);
                ext_val[i] <= pol[0];
                @(posedge ref_clk);
                ext_val[i] <= !pol[0];
                repeat (6) @(posedge ref_clk);
                wb(1'b0, gpio_pkg::IRQ_STATUS_OFF, 32'h0, rd);
                chk("status_short", 32'h0, rd);
                ext_val[i] <= pol[0];
                repeat (6) @(posedge ref_clk);
                chk("irq_on", 32'h1, 32'(irq_o));
                wb(1'b0, gpio_pkg::IRQ_STATUS_OFF, 32'h0, rd);
                chk("status_set", 32'(act), rd);
                wb(1'b1, gpio_pkg::IRQ_ENABLE_OFF, 32'h0, rd);
                repeat (2) @(posedge ref_clk);
                chk("irq_masked", 32'h0, 32'(irq_o));
                ext_val[i] <= !pol[0];
                repeat (4) @(posedge ref_clk);
                wb(1'b1, gpio_pkg::IRQ_STATUS_OFF, 32'(act), rd);
                wb(1'b0, gpio_pkg::IRQ_STATUS_OFF, 32'h0, rd);
                chk("status_clear", 32'h0, rd);
            end
        end
        // set status, then reset in mid-run with controller inputs left busy
        ext_val <= 3'h7;
        repeat (4) @(posedge ref_clk);
        wb(1'b0, gpio_pkg::IRQ_STATUS_OFF, 32'h0, rd);
        chk("status_pre", 32'h7, rd);
        ext_en <= 3'h0;
        sys_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        // third edge: the data pin copy has seen the controller drive again
        repeat (3) @(posedge ref_clk);
        chk("irq_reset", 32'h0, 32'(irq_o));
        check_pins(32'h0);
        wb(1'b0, gpio_pkg::PIN_CONFIG_OFF, 32'h0, rd);
        chk("cfg_rereset", 32'h7, rd);
        wb(1'b0, gpio_pkg::IRQ_STATUS_OFF, 32'h0, rd);
        chk("status_reset", 32'h0, rd);
        test_done();
    end
endmodule
